// >>> verilog/iofef_top.sv
// Fault entry formatter: turns one scan's status bytes into entry
// registers 5 to 10, keeps edge memory and a sweep-driven BCD stamp.
// Assumes status bytes and sweep strobe come from logic on clk_i.
//
// Summary of operation
// - Status byte 6 goes unchanged into low byte of entry register 5.
// - Register 5 high byte: one flag per fault category, bit 7 zero.
// - No-response flag set when controller answered before but gave no input last scan.
// - Alive bit in the input image is cleared after each check without a reply in the same cycle.
// - Alive copied to control byte 5 bit 0; log on 1 to 0 only.
// - Other errors ignored while the controller is not alive.
// - Serial error from byte 1 bit 1, edge memory in control bit 1.
// - Flags 2 to 5 come from status byte 1 bits 2 to 5.
// - Memory failure: byte 5 zero, byte 1 bit 2, byte 6 bit 3 set.
// - Low nibble of byte 5 always into register 6 bits 0-3.
// - Block-type nibble decoded, other patterns passed unchanged.
// - Discrete fault: byte 6 to register 6 high, register 7 cleared.
// - Register 6 high byte holds discrete fault bits 8-13, 14-15 zero.
// - Analog fault: byte 6 to register 7 low, high bytes cleared.
// - Register 7 low byte holds analog bits 0-6, bit 7 zero.
// - Other faults clear register 7 and register 6 high byte.
// - Register 7 high byte always zero.
// - Clock advances once per sweep in run and stop, not unpowered.
// - Stamp is BCD: seconds/tenths, hours/minutes, hundreds/days.
// - Each entry takes ten registers after the count register.
// - No entries once count reaches capacity; software lowers count.
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module iofef_top
   import iofef_pkg::*;
#(
   parameter int CNT_W = 16
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic        scan_valid_i,
   input  wire logic [7:0]  stat1_i,
   input  wire logic [7:0]  stat5_i,
   input  wire logic [7:0]  stat6_i,
   input  wire logic        sweep_i,
   input  wire logic        power_ok_i,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [7:0]  s_axi_araddr,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             entry_push_o,
   output logic [7:0]       ctrl_byte5_o
);
   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   // BCD byte increment with wrap at the given limit
   function automatic logic [8:0] bcd_inc(input logic [7:0] v,
                                          input logic [7:0] lim);
      logic [7:0] r;
      r = 8'h00;
      if (v == lim) begin
         return {1'b1, 8'h00};
      end
      if (v[3:0] == 4'h9) begin
         r = {v[7:4] + 4'h1, 4'h0};
      end else begin
         r = {v[7:4], v[3:0] + 4'h1};
      end
      return {1'b0, r};
   endfunction

   // ----------------------------------------------------------------
   // Diagnostic pass
   // ----------------------------------------------------------------
   logic        alive_img_ff;
   logic        scan_seen_ff;
   logic [7:0]  ctrl5_ff;
   logic [15:0] reg5_ff;
   logic [15:0] reg6_ff;
   logic [15:0] reg7_ff;
   logic [15:0] count_ff;
   logic [15:0] cap_ff;
   logic        push_ff;

   // relies on alive sent each scan
   wire alive       = scan_valid_i & stat1_i[IOFEF_BIT_ALIVE];
   wire diag_pass   = sweep_i;
   wire noresp_new  = ~alive_img_ff & ctrl5_ff[IOFEF_BIT_ALIVE];
   wire serial_now  = alive_img_ff & stat1_i[IOFEF_BIT_SERIAL];
   wire serial_new  = serial_now & ~ctrl5_ff[IOFEF_BIT_SERIAL];
   wire [7:0] st1   = alive_img_ff ? stat1_i : 8'h00;
   wire nvm_fail    = (stat5_i == 8'h00) & st1[IOFEF_BIT_CIRCUIT]
                      & stat6_i[IOFEF_BIT_NVM_S6];
   wire [7:0] ftype = {1'b0, nvm_fail, st1[5:2], serial_new,
                       noresp_new};
   wire any_fault   = |ftype;
   wire table_full  = (count_ff >= cap_ff);
   wire [3:0] btype = stat5_i[3:0];
   wire is_disc     = ftype[IOFEF_BIT_CIRCUIT]
                      & (btype == IOFEF_BT_DISCRETE);
   wire is_ana      = ftype[IOFEF_BIT_CIRCUIT]
                      & (btype == IOFEF_BT_ANALOG);
   // bits 14 and 15 forced zero
   wire [7:0] r6_hi = is_disc ? {2'b00, stat6_i[5:0]} : 8'h00;
   wire [15:0] nxt_reg7 = is_ana ? {8'h00, 1'b0, stat6_i[6:0]} : 16'h0000;
   wire [15:0] nxt_reg6 = {r6_hi, 4'h0, btype};
   wire [15:0] nxt_reg5 = {ftype, stat6_i};
   wire do_push = diag_pass & any_fault & ~table_full;

   // A reply in the sweep cycle wins over the clear and is kept
   // alive image captured then cleared
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         alive_img_ff <= 1'b0;
         scan_seen_ff <= 1'b0;
      end else if (ce_i) begin
         if (alive) begin
            alive_img_ff <= 1'b1;
         end else if (diag_pass) begin
            alive_img_ff <= 1'b0;
         end
         scan_seen_ff <= scan_valid_i;
      end
   end

   // alive state into control bit 0
   // serial state into control bit 1
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl5_ff <= IOFEF_RST_CTRLOUT;
      end else if (ce_i && diag_pass) begin
         ctrl5_ff[IOFEF_BIT_ALIVE]  <= alive_img_ff;
         ctrl5_ff[IOFEF_BIT_SERIAL] <= serial_now;
      end
   end

   // one entry of ten registers per push
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         reg5_ff <= 16'h0000;
         reg6_ff <= 16'h0000;
         reg7_ff <= 16'h0000;
         push_ff <= 1'b0;
      end else if (ce_i) begin
         push_ff <= do_push;
         if (do_push) begin
            reg5_ff <= nxt_reg5;
            reg6_ff <= nxt_reg6;
            reg7_ff <= nxt_reg7;
         end
      end
   end

   // ----------------------------------------------------------------
   // Time stamp
   // ----------------------------------------------------------------
   logic [7:0] tenth_ff;
   logic [7:0] sec_ff;
   logic [7:0] min_ff;
   logic [7:0] hour_ff;
   logic [7:0] day_ff;
   logic [7:0] hday_ff;
   logic [15:0] st_s_ff;
   logic [15:0] st_hm_ff;
   logic [15:0] st_d_ff;

   wire [8:0] t_n = bcd_inc(tenth_ff, IOFEF_TENTH_MAX);
   wire [8:0] s_n = bcd_inc(sec_ff,   IOFEF_MINSEC_MAX);
   wire [8:0] m_n = bcd_inc(min_ff,   IOFEF_MINSEC_MAX);
   wire [8:0] h_n = bcd_inc(hour_ff,  IOFEF_HOUR_MAX);
   wire [8:0] d_n = bcd_inc(day_ff,   IOFEF_DAY_MAX);
   wire [8:0] x_n = bcd_inc(hday_ff,  IOFEF_DAY_MAX);
   wire tick = sweep_i & power_ok_i;
   // carries ripple from tenths up to hundreds of days
   wire c_s  = t_n[8];
   wire c_m  = c_s & s_n[8];
   wire c_h  = c_m & m_n[8];
   wire c_d  = c_h & h_n[8];
   wire c_x  = c_d & d_n[8];

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tenth_ff <= 8'h00;
         sec_ff   <= 8'h00;
         min_ff   <= 8'h00;
         hour_ff  <= 8'h00;
         day_ff   <= 8'h00;
         hday_ff  <= 8'h00;
      end else if (ce_i && tick) begin
         tenth_ff <= t_n[7:0];
         if (c_s) begin
            sec_ff <= s_n[7:0];
         end
         if (c_m) begin
            min_ff <= m_n[7:0];
         end
         if (c_h) begin
            hour_ff <= h_n[7:0];
         end
         if (c_d) begin
            day_ff <= d_n[7:0];
         end
         if (c_x) begin
            hday_ff <= x_n[7:0];
         end
      end
   end

   // Stamp latched with the entry so it marks the fault's sweep
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_s_ff  <= 16'h0000;
         st_hm_ff <= 16'h0000;
         st_d_ff  <= 16'h0000;
      end else if (ce_i && do_push) begin
         st_s_ff  <= {sec_ff, tenth_ff};
         st_hm_ff <= {hour_ff, min_ff};
         st_d_ff  <= {hday_ff, day_ff};
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------
   logic       aw_ok_ff;
   logic       w_ok_ff;
   logic [7:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0]  wstrb_ff;

   wire wr_go   = aw_ok_ff & w_ok_ff & ~s_axi_bvalid;
   wire wr_cnt  = wr_go & (awaddr_ff == IOFEF_OFF_COUNT);
   wire wr_cap  = wr_go & (awaddr_ff == IOFEF_OFF_CAPACITY);
   wire wr_map  = wr_cnt | wr_cap |
                  (awaddr_ff == IOFEF_OFF_CONTROL);
   wire [15:0] wr16 = {wstrb_ff[1] ? wdata_ff[15:8] : count_ff[15:8],
                       wstrb_ff[0] ? wdata_ff[7:0]  : count_ff[7:0]};
   wire [15:0] wc16 = {wstrb_ff[1] ? wdata_ff[15:8] : cap_ff[15:8],
                       wstrb_ff[0] ? wdata_ff[7:0]  : cap_ff[7:0]};

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         aw_ok_ff      <= 1'b0;
         w_ok_ff       <= 1'b0;
         awaddr_ff     <= 8'h00;
         wdata_ff      <= 32'h0000_0000;
         wstrb_ff      <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= IOFEF_RESP_OKAY;
      end else if (ce_i) begin
         s_axi_awready <= ~aw_ok_ff & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready  <= ~w_ok_ff & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_ok_ff  <= 1'b1;
            awaddr_ff <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_ok_ff  <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_map ? IOFEF_RESP_OKAY : IOFEF_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_ok_ff     <= 1'b0;
            w_ok_ff      <= 1'b0;
         end
      end
   end

   // count advances, software may lower it
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         count_ff <= IOFEF_RST_COUNT;
         cap_ff   <= IOFEF_RST_CAPACITY;
      end else if (ce_i) begin
         // Push wins over a same-cycle write so no entry goes uncounted
         if (do_push) begin
            count_ff <= count_ff + 16'h0001;
         end else if (wr_cnt) begin
            count_ff <= wr16;
         end
         if (wr_cap) cap_ff <= wc16;
      end
   end

   // Read mux
   wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
   logic [31:0] rmux;
   logic        rhit;
   always_comb begin
      rhit = 1'b1;
      case (ra)
         IOFEF_OFF_STATUS:   rmux = {29'h0, table_full, scan_seen_ff,
                                     alive_img_ff};
         IOFEF_OFF_COUNT:    rmux = {16'h0000, count_ff};
         IOFEF_OFF_CAPACITY: rmux = {16'h0000, cap_ff};
         IOFEF_OFF_CTRLOUT:  rmux = {24'h000000, ctrl5_ff};
         IOFEF_OFF_REG5:     rmux = {16'h0000, reg5_ff};
         IOFEF_OFF_REG6:     rmux = {16'h0000, reg6_ff};
         IOFEF_OFF_REG7:     rmux = {16'h0000, reg7_ff};
         IOFEF_OFF_STAMP_S:  rmux = {16'h0000, st_s_ff};
         IOFEF_OFF_STAMP_HM: rmux = {16'h0000, st_hm_ff};
         IOFEF_OFF_STAMP_D:  rmux = {16'h0000, st_d_ff};
         IOFEF_OFF_CONTROL:  rmux = 32'h0000_0000;
         default: begin
            rmux = 32'h0000_0000;
            rhit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= IOFEF_RESP_OKAY;
      end else if (ce_i) begin
         s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rmux;
            s_axi_rresp  <= rhit ? IOFEF_RESP_OKAY : IOFEF_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Ports re-registered so every output comes from a flip-flop
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         entry_push_o <= 1'b0;
         ctrl_byte5_o <= IOFEF_RST_CTRLOUT;
      end else if (ce_i) begin
         entry_push_o <= push_ff;
         ctrl_byte5_o <= ctrl5_ff;
      end
   end
endmodule

// >>> verilog/iofef_pkg.sv
// Package: constants for the fault entry formatter.
// Assumes a 32-bit AXI4-Lite register bus, one word per register.
package iofef_pkg;
   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] IOFEF_OFF_STATUS     = 8'h00;
   localparam logic [7:0] IOFEF_OFF_COUNT      = 8'h04;
   localparam logic [7:0] IOFEF_OFF_CAPACITY   = 8'h08;
   localparam logic [7:0] IOFEF_OFF_CTRLOUT    = 8'h0c;
   localparam logic [7:0] IOFEF_OFF_REG5       = 8'h10;
   localparam logic [7:0] IOFEF_OFF_REG6       = 8'h14;
   localparam logic [7:0] IOFEF_OFF_REG7       = 8'h18;
   localparam logic [7:0] IOFEF_OFF_STAMP_S    = 8'h1c;
   localparam logic [7:0] IOFEF_OFF_STAMP_HM   = 8'h20;
   localparam logic [7:0] IOFEF_OFF_STAMP_D    = 8'h24;
   localparam logic [7:0] IOFEF_OFF_CONTROL    = 8'h28;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int IOFEF_BIT_ALIVE   = 0;
   localparam int IOFEF_BIT_SERIAL  = 1;
   localparam int IOFEF_BIT_CIRCUIT = 2;
   localparam int IOFEF_BIT_LOST    = 3;
   localparam int IOFEF_BIT_ADDED   = 4;
   localparam int IOFEF_BIT_CONFL   = 5;
   localparam int IOFEF_BIT_NVM     = 6;
   localparam int IOFEF_BIT_NVM_S6  = 3;
   localparam int IOFEF_FLAG_NORESP = 0;
   // ----------------------------------------------------------------
   // Block-type codes and reset values
   // ----------------------------------------------------------------
   localparam logic [3:0] IOFEF_BT_HEADEND  = 4'h0;
   localparam logic [3:0] IOFEF_BT_DISCRETE = 4'h1;
   localparam logic [3:0] IOFEF_BT_ANALOG   = 4'h2;
   localparam logic [15:0] IOFEF_RST_COUNT    = 16'h0000;
   localparam logic [15:0] IOFEF_RST_CAPACITY = 16'h0008;
   localparam logic [7:0]  IOFEF_RST_CTRLOUT  = 8'h00;
   localparam logic [1:0]  IOFEF_RESP_OKAY    = 2'b00;
   localparam logic [1:0]  IOFEF_RESP_SLVERR  = 2'b10;
   localparam int IOFEF_REGS_PER_ENTRY = 10;
   localparam logic [7:0]  IOFEF_TENTH_MAX    = 8'h09;
   localparam logic [7:0]  IOFEF_MINSEC_MAX   = 8'h59;
   localparam logic [7:0]  IOFEF_HOUR_MAX     = 8'h23;
   localparam logic [7:0]  IOFEF_DAY_MAX      = 8'h99;
endpackage

// >>> verification/iofef_sva.sv
// Checker: port-level properties of the fault entry formatter.
// Assumes ce_i held high and no scan in the same cycle as a sweep.
`timescale 1ns/1ps
module iofef_sva
   import iofef_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        scan_valid_i,
   input wire logic [7:0]  stat1_i,
   input wire logic        sweep_i,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        entry_push_o,
   input wire logic [7:0]  ctrl_byte5_o
);
   // ----------------------------------------------------------------
   // Shadow of the alive image and of the last read address
   // ----------------------------------------------------------------
   logic       alive_ff;
   logic [7:0] raddr_ff;
   wire        rd_ok = s_axi_rvalid && (s_axi_rresp == IOFEF_RESP_OKAY);
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         alive_ff <= 1'b0;
         raddr_ff <= 8'h00;
      end else begin
         if (sweep_i) alive_ff <= 1'b0;
         else if (scan_valid_i && stat1_i[0]) alive_ff <= 1'b1;
         if (s_axi_arvalid && s_axi_arready) raddr_ff <= s_axi_araddr;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   sequence s_dead_sweep;
      sweep_i && !alive_ff && !ctrl_byte5_o[0];
   endsequence
   sequence s_serial_held;
      sweep_i && alive_ff && ctrl_byte5_o[1] && stat1_i[1]
         && (stat1_i[5:2] == 4'h0);
   endsequence
   property p_alive_copy;
      sweep_i |-> ##2 ctrl_byte5_o[0] == $past(alive_ff, 2);
   endproperty
   property p_serial_mem;
      sweep_i && alive_ff |-> ##2 ctrl_byte5_o[1] == $past(stat1_i[1], 2);
   endproperty
   property p_push_cause;
      entry_push_o |-> $past(sweep_i, 2);
   endproperty
   property p_dead_quiet;
      s_dead_sweep |-> ##2 !entry_push_o;
   endproperty
   property p_serial_once;
      s_serial_held |-> ##2 !entry_push_o;
   endproperty
   property p_reg5_fixed;
      rd_ok && raddr_ff == IOFEF_OFF_REG5 |-> !s_axi_rdata[15];
   endproperty
   property p_reg6_fixed;
      rd_ok && raddr_ff == IOFEF_OFF_REG6
         |-> s_axi_rdata[15:14] == 2'h0 && s_axi_rdata[7:4] == 4'h0;
   endproperty
   property p_reg7_fixed;
      rd_ok && raddr_ff == IOFEF_OFF_REG7 |-> s_axi_rdata[15:7] == 9'h000;
   endproperty
   a_alive_copy: assert property (p_alive_copy)
      else $error("alive memory bit wrong");
   a_serial_mem: assert property (p_serial_mem)
      else $error("serial memory bit wrong");
   a_push_cause: assert property (p_push_cause)
      else $error("entry without sweep");
   a_dead_quiet: assert property (p_dead_quiet)
      else $error("entry from silent controller");
   a_serial_once: assert property (p_serial_once)
      else $error("serial fault logged twice");
   a_reg5_fixed: assert property (p_reg5_fixed)
      else $error("fault type bit 7 set");
   a_reg6_fixed: assert property (p_reg6_fixed)
      else $error("unused register 6 bits set");
   a_reg7_fixed: assert property (p_reg7_fixed)
      else $error("reserved register 7 bits set");
endmodule
bind iofef_top iofef_sva i_sva (
   .clk_i(clk_i), .rst_i(rst_i), .scan_valid_i(scan_valid_i),
   .stat1_i(stat1_i), .sweep_i(sweep_i), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .entry_push_o(entry_push_o),
   .ctrl_byte5_o(ctrl_byte5_o));

// >>> verification/iofef_ctrl_model.sv
// Model of the remote bus controller delivering one scan of status.
// Assumes scan() is called right after a rising clock edge.
`timescale 1ns/1ps
module iofef_ctrl_model (
   input  wire logic  clk_i,
   output logic       scan_valid_o,
   output logic [7:0] stat1_o,
   output logic [7:0] stat5_o,
   output logic [7:0] stat6_o
);
   initial begin
      scan_valid_o = 1'b0;
      stat1_o = 8'h00;
      stat5_o = 8'h00;
      stat6_o = 8'h00;
   end
   // Bytes stay put after a silent scan: they model an image, not a wire
   task automatic scan(input logic r, input logic [7:0] s1, s5, s6);
      scan_valid_o <= r;
      // alive as 1 on every answered scan
      stat1_o <= r ? (s1 | 8'h01) : s1;
      stat5_o <= s5;
      stat6_o <= s6;
      @(posedge clk_i);
      scan_valid_o <= 1'b0;
   endtask
endmodule

// >>> verification/iofef_tb.sv
// Testbench: scans, sweeps and register reads of the formatter.
// Assumes the package, design, model and checker are compiled first.
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin \
   err_total++; $display("unexpected at %0t: %h not %h", $time, a, e); \
   end end
module testbench
   import iofef_pkg::*;
;
   logic        clk_i = 1'b0, rst_i = 1'b1, sweep_i = 1'b0;
   logic        power_ok_i = 1'b1, scan_valid_i, entry_push_o;
   logic [7:0]  stat1_i, stat5_i, stat6_i, ctrl_byte5_o;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
   logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic [15:0] cnt_e = 16'h0, t0;
   int          err_total = 0, num_checks = 0;
   always #4 clk_i = ~clk_i;
   iofef_ctrl_model i_iofef_ctrl_model (.clk_i(clk_i),
      .scan_valid_o(scan_valid_i), .stat1_o(stat1_i),
      .stat5_o(stat5_i), .stat6_o(stat6_i));
   iofef_top i_iofef_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
      .scan_valid_i(scan_valid_i), .stat1_i(stat1_i), .stat5_i(stat5_i),
      .stat6_i(stat6_i), .sweep_i(sweep_i), .power_ok_i(power_ok_i),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(4'hf), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .entry_push_o(entry_push_o),
      .ctrl_byte5_o(ctrl_byte5_o));
   // ----------------------------------------------------------------
   // Bus and scan tasks
   // ----------------------------------------------------------------
   task automatic end_sim();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      int n = 0;
      logic got = 1'b0;
      s_axi_awvalid <= 1'b1;
      s_axi_awaddr <= a;
      s_axi_wvalid <= 1'b1;
      s_axi_wdata <= v;
      s_axi_bready <= 1'b1;
      while (!got && n < 50) begin
         @(posedge clk_i);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            s_axi_bready <= 1'b0;
            r = s_axi_bresp;
            got = 1'b1;
         end
      end
      @(posedge clk_i);
      if (!got) begin
         err_total++;
         end_sim();
      end
   endtask
   task automatic rd(input logic [7:0] a);
      int n = 0;
      logic got = 1'b0;
      s_axi_arvalid <= 1'b1;
      s_axi_araddr <= a;
      s_axi_rready <= 1'b1;
      while (!got && n < 50) begin
         @(posedge clk_i);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            s_axi_rready <= 1'b0;
            d = s_axi_rdata;
            r = s_axi_rresp;
            got = 1'b1;
         end
      end
      @(posedge clk_i);
      if (!got) begin
         err_total++;
         end_sim();
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic [15:0] e);
      rd(a);
      `CHK({r, d}, {IOFEF_RESP_OKAY, 16'h0000, e})
   endtask
   task automatic fault(input logic v, input logic [7:0] s1, s5, s6,
                        input logic p);
      logic [2:0] got = 3'h0;
      i_iofef_ctrl_model.scan(v, s1, s5, s6);
      sweep_i <= 1'b1;
      @(posedge clk_i);
      sweep_i <= 1'b0;
      repeat (6) begin
         @(posedge clk_i);
         if (entry_push_o) got++;
      end
      `CHK(got, {2'b00, p})
      cnt_e = cnt_e + {15'h0, p};
      rc(IOFEF_OFF_COUNT, cnt_e);
   endtask
   task automatic entry(input logic [15:0] e5, e6, e7);
      rc(IOFEF_OFF_REG5, e5);
      rc(IOFEF_OFF_REG6, e6);
      rc(IOFEF_OFF_REG7, e7);
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      rc(IOFEF_OFF_COUNT, IOFEF_RST_COUNT);
      rc(IOFEF_OFF_CAPACITY, IOFEF_RST_CAPACITY);
      rd(8'h3c);
      `CHK({r, d}, {IOFEF_RESP_SLVERR, 32'h0})
      fault(1'b1, 8'h04, 8'h31, 8'hea, 1'b1);
      entry(16'h04ea, 16'h2a01, 16'h0000);
      fault(1'b1, 8'h04, 8'h12, 8'hc5, 1'b1);
      entry(16'h04c5, 16'h0002, 16'h0045);
      fault(1'b1, 8'h04, 8'h00, 8'h08, 1'b1);
      entry(16'h4408, 16'h0000, 16'h0000);
      fault(1'b1, 8'h04, 8'h00, 8'h00, 1'b1);
      entry(16'h0400, 16'h0000, 16'h0000);
      fault(1'b1, 8'h38, 8'h97, 8'h81, 1'b1);
      entry(16'h3881, 16'h0007, 16'h0000);
      fault(1'b1, 8'h02, 8'h00, 8'h00, 1'b1);
      rc(IOFEF_OFF_REG5, 16'h0200);
      fault(1'b1, 8'h02, 8'h00, 8'h00, 1'b0);
      `CHK(ctrl_byte5_o[1:0], 2'b11)
      fault(1'b0, 8'h00, 8'h00, 8'h00, 1'b1);
      rc(IOFEF_OFF_REG5, 16'h0100);
      `CHK(ctrl_byte5_o[0], 1'b0)
      fault(1'b0, 8'h3e, 8'h00, 8'h00, 1'b0);
      fault(1'b1, 8'h00, 8'h00, 8'h00, 1'b0);
      wr(IOFEF_OFF_CAPACITY, {16'h0, cnt_e});
      `CHK(r, IOFEF_RESP_OKAY)
      fault(1'b1, 8'h08, 8'h00, 8'h00, 1'b0);
      rc(IOFEF_OFF_STATUS, 16'h0004);
      wr(IOFEF_OFF_COUNT, 32'h0);
      `CHK(r, IOFEF_RESP_OKAY)
      cnt_e = 16'h0;
      fault(1'b1, 8'h08, 8'h00, 8'h00, 1'b1);
      wr(IOFEF_OFF_CTRLOUT, 32'hff);
      `CHK(r, IOFEF_RESP_SLVERR)
      rc(IOFEF_OFF_CTRLOUT, 16'h0001);
      // Stamp step size is open, so only freezing, change and BCD digit ranges are judged
      power_ok_i <= 1'b0;
      fault(1'b1, 8'h08, 8'h00, 8'h00, 1'b1);
      rd(IOFEF_OFF_STAMP_S);
      t0 = d[15:0];
      fault(1'b1, 8'h08, 8'h00, 8'h00, 1'b1);
      rc(IOFEF_OFF_STAMP_S, t0);
      power_ok_i <= 1'b1;
      fault(1'b1, 8'h08, 8'h00, 8'h00, 1'b1);
      fault(1'b1, 8'h08, 8'h00, 8'h00, 1'b1);
      rd(IOFEF_OFF_STAMP_S);
      `CHK(d[15:0] != t0, 1'b1)
      `CHK(d[15:8] <= 8'h59 && d[7:0] <= 8'h09, 1'b1)
      rd(IOFEF_OFF_STAMP_HM);
      `CHK(d[15:8] <= 8'h23 && d[7:4] <= 4'h5 && d[3:0] <= 4'h9, 1'b1)
      end_sim();
   end
endmodule
